// ==== common/lcw_pkg.sv ====
package lcw_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL   = 4'h0;  // display_control_reg
   localparam logic [3:0] ADDR_STATUS = 4'h1;  // Status, read only
   localparam logic [3:0] ADDR_MEM    = 4'h2;  // Display memory window
   localparam int         ADDR_W      = 4;
   localparam int         MEM_OFS_W   = 2;

   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_BIT   = 0;  // display_drive_enable
   localparam int CTRL_TYPE_BIT = 1;  // Waveform type B when set
   localparam int CTRL_BIAS_BIT = 2;  // bias_method_select, 1 = C type
   localparam int CTRL_SLP_BIT  = 3;  // Software sleep request
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ------------------------------------------------------------
   // Drive geometry and timing
   // ------------------------------------------------------------
   localparam int NUM_COM    = 4;   // One quarter duty
   localparam int SLOT_W     = 2;
   localparam int NUM_LEVELS = 4;   // One third bias levels
   localparam int LVL_W      = 2;
   localparam int DIV_DEF    = 1000; // Clocks per half time slot

   // Drive level codes: ground, then three bias levels rising to VA
   typedef enum logic [1:0]
   {
      LVL_GND = 2'h0,
      LVL_VC  = 2'h1,
      LVL_VB  = 2'h2,
      LVL_VA  = 2'h3
   } lcw_level_t;

   // Control bits as a bundle
   typedef struct packed
   {
      logic sleep;
      logic bias_c;
      logic type_b;
      logic enable;
   } lcw_ctrl_t;

endpackage : lcw_pkg

// ==== rtl/lcw_driver.sv ====
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
module lcw_driver
   import lcw_pkg::*;
#(
   parameter int NUM_SEG = 16,      // Segment lines
   parameter int DIV     = DIV_DEF  // Clocks per half slot
)
(
   input  wire logic                       clock,
   input  wire logic                       srst,
   input  wire logic [ADDR_W-1:0]          avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       sleep_in,
   output logic      [NUM_COM*LVL_W-1:0]   com_level,
   output logic      [NUM_SEG*LVL_W-1:0]   seg_level,
   output logic                            charge_pump_on,
   output logic                            bias_c_type
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   localparam int DIV_W = $clog2(DIV + 1);

   lcw_ctrl_t                 ctrl_r;        // Control register
   logic [NUM_SEG-1:0]        mem_r [NUM_COM]; // One word per common
   logic                      ack_r;         // Bus answer phase
   logic [31:0]               rdata_nxt;     // Read mux
   logic                      lcd_rst;       // Internal driver reset
   logic [DIV_W-1:0]          div_r;         // Half slot divider
   logic                      tick;          // Half slot enable
   logic                      half_r;        // Second half of slot
   logic [SLOT_W-1:0]         slot_r;        // Active common
   logic                      pol_r;         // Drive polarity
   logic                      acc;           // Bus access present

   // Memory window hit for word i, shared by write and read paths
   function automatic logic mem_sel(input logic [ADDR_W-1:0] a,
                                    input int               i);
      return a == ADDR_MEM + ADDR_W'(i);
   endfunction : mem_sel

   // ------------------------------------------------------------
   // Bus slave: one wait cycle, then answer
   // ------------------------------------------------------------
   assign acc = (avs_read | avs_write) & ~ack_r;

   // Answer a cycle after the request is seen
   always_ff @(posedge clock)
   begin
      if (srst)
         ack_r <= 1'b0;
      else
         ack_r <= acc;
   end

   // Waitrequest stays high until answer cycle
   always_ff @(posedge clock)
   begin
      if (srst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~acc;
   end

   // Control register writes, low byte lane, in the answer cycle
   // so the write lands on the edge the master sees waitrequest low
   always_ff @(posedge clock)
   begin
      if (srst)
         ctrl_r <= lcw_ctrl_t'(CTRL_RESET);
      else if (ack_r && avs_write && avs_byteenable[0]
               && avs_address == ADDR_CTRL)
      begin
         ctrl_r.enable <= avs_writedata[CTRL_EN_BIT];
         ctrl_r.type_b <= avs_writedata[CTRL_TYPE_BIT];
         ctrl_r.bias_c <= avs_writedata[CTRL_BIAS_BIT];
         ctrl_r.sleep  <= avs_writedata[CTRL_SLP_BIT];
      end
   end

   // Display memory writes; contents undefined until written
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < NUM_COM; i++)
      begin
         if (ack_r && avs_write && mem_sel(avs_address, i))
            mem_r[i] <= avs_writedata[NUM_SEG-1:0];
      end
   end

   // Read data selection
   always_comb
   begin
      rdata_nxt = '0;
      case (avs_address)
         ADDR_CTRL:
            rdata_nxt = {28'h0, ctrl_r};
         ADDR_STATUS:
            rdata_nxt = {26'h0, pol_r, half_r, slot_r, lcd_rst,
                         charge_pump_on};
         default:
         begin
            // Memory window, unmapped reads as zero
            for (int i = 0; i < NUM_COM; i++)
            begin
               if (mem_sel(avs_address, i))
                  rdata_nxt[NUM_SEG-1:0] = mem_r[i];
            end
         end
      endcase
   end

   // Registered read data
   always_ff @(posedge clock)
   begin
      if (srst)
         avs_readdata <= '0;
      else if (acc && avs_read)
         avs_readdata <= rdata_nxt;
   end

   // ------------------------------------------------------------
   // Timing chain
   // ------------------------------------------------------------
   assign lcd_rst = ~ctrl_r.enable | ctrl_r.sleep | sleep_in;

   // Half slot divider
   always_ff @(posedge clock)
   begin
      if (srst || lcd_rst)
         div_r <= '0;
      else if (tick)
         div_r <= '0;
      else
         div_r <= div_r + DIV_W'(1);
   end
   assign tick = (div_r == DIV_W'(DIV - 1));

   // Slot sequencer; type A flips polarity inside each slot,
   // type B flips once per frame
   always_ff @(posedge clock)
   begin
      if (srst || lcd_rst)
      begin
         half_r <= 1'b0;
         slot_r <= '0;
         pol_r  <= 1'b0;
      end
      else if (tick)
      begin
         half_r <= ~half_r;
         if (half_r)
            slot_r <= slot_r + SLOT_W'(1);
         if (!ctrl_r.type_b)
            pol_r <= ~pol_r;
         else if (half_r && slot_r == SLOT_W'(NUM_COM - 1))
            pol_r <= ~pol_r;
      end
   end

   // ------------------------------------------------------------
   // Drive levels
   // ------------------------------------------------------------
   // Common: select at VA or ground, non-select at VC or VB
   always_ff @(posedge clock)
   begin
      for (int c = 0; c < NUM_COM; c++)
      begin
         if (srst || lcd_rst)
            com_level[c*LVL_W +: LVL_W] <= LVL_GND;
         else if (slot_r == SLOT_W'(c))
            com_level[c*LVL_W +: LVL_W] <=
               pol_r ? LVL_GND : LVL_VA;
         else
            com_level[c*LVL_W +: LVL_W] <= pol_r ? LVL_VB : LVL_VC;
      end
   end

   // Segment: on drives opposite full swing, off mid levels
   always_ff @(posedge clock)
   begin
      for (int s = 0; s < NUM_SEG; s++)
      begin
         if (srst || lcd_rst)
            seg_level[s*LVL_W +: LVL_W] <= LVL_GND;
         else if (mem_r[slot_r][s])
            seg_level[s*LVL_W +: LVL_W] <=
               pol_r ? LVL_VA : LVL_GND;
         else
            seg_level[s*LVL_W +: LVL_W] <= pol_r ? LVL_VC : LVL_VB;
      end
   end

   // Bias selection outputs
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         charge_pump_on <= 1'b0;
         bias_c_type    <= 1'b0;
      end
      else
      begin
         charge_pump_on <= ctrl_r.bias_c & ~lcd_rst;
         bias_c_type    <= ctrl_r.bias_c;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_off_com_gnd: assert property (@(posedge clock) disable iff (srst)
      $past(lcd_rst) |-> com_level == '0)
      else $error("Commons not low while driver reset");
   a_off_seg_gnd: assert property (@(posedge clock) disable iff (srst)
      $past(lcd_rst) |-> seg_level == '0)
      else $error("Segments not low while driver reset");
   a_en_reset: assert property (@(posedge clock)
      $past(srst) |-> !ctrl_r.enable)
      else $error("Enable not cleared by reset");
   a_pump_bias: assert property (@(posedge clock) disable iff (srst)
      $past(!ctrl_r.bias_c) |-> !charge_pump_on)
      else $error("Charge pump on with resistor bias");
   a_type_a_flip: assert property (@(posedge clock) disable iff (srst)
      (tick && !lcd_rst && !ctrl_r.type_b) |=> pol_r != $past(pol_r))
      else $error("Type A polarity did not flip");
   a_type_b_hold: assert property (@(posedge clock) disable iff (srst)
      (tick && !lcd_rst && ctrl_r.type_b && !half_r) |=> $stable(pol_r))
      else $error("Type B polarity flipped early");
   a_slot_step: assert property (@(posedge clock) disable iff (srst)
      (tick && half_r && !lcd_rst)
      |=> slot_r == $past(slot_r) + SLOT_W'(1))
      else $error("Slot did not advance");
   a_ctrl_write: assert property (@(posedge clock) disable iff (srst)
      (ack_r && avs_write && avs_byteenable[0] && avs_address == ADDR_CTRL)
      |=> ctrl_r.type_b == $past(avs_writedata[CTRL_TYPE_BIT]))
      else $error("Type bit not written");
   a_sel_level: assert property (@(posedge clock) disable iff (srst)
      (!lcd_rst && !pol_r && slot_r == '0) |=>
      (lcd_rst || com_level[LVL_W-1:0] == LVL_VA))
      else $error("Selected common not at full level");

   c_type_b_frame: cover property (@(posedge clock) disable iff (srst)
      ctrl_r.type_b && tick && half_r && slot_r == SLOT_W'(NUM_COM - 1));
   c_pump_on: cover property (@(posedge clock) charge_pump_on);
   c_sleep_stop: cover property (@(posedge clock) disable iff (srst)
      ctrl_r.enable && sleep_in);

endmodule : lcw_driver

// ==== verification/lcw_panel.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Passive glass, pixel com0 by seg0
// ----------------------------------------
module lcw_panel
   import lcw_pkg::*;
#(
   parameter int NUM_SEG = 16  // Segment lines
)
(
   input  wire logic [NUM_COM*LVL_W-1:0] com_level,
   input  wire logic [NUM_SEG*LVL_W-1:0] seg_level,
   input  wire logic                     clock,
   output int                            dc_sum
);
   initial dc_sum = 0;
   // Net drive on the pixel; stays bounded only if polarity alternates
   always @(posedge clock)
   begin
      dc_sum <= dc_sum + int'(com_level[1:0]) - int'(seg_level[1:0]);
   end
endmodule : lcw_panel

// ==== verification/tb_lcw_driver.sv ====
`timescale 1ns/100ps
module tb_lcw_driver;
   import lcw_pkg::*;
   localparam int DV = 2;  // Short half slot
   logic        clock, srst, avs_read, avs_write, sleep_in, mon_on, first;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q, ec, es;
   logic        avs_waitrequest, charge_pump_on, bias_c_type, pol;
   logic [7:0]  com_level, prev_com;
   logic [31:0] seg_level;
   logic [15:0] mem [4] = '{16'h0001, 16'h8002, 16'h00f0, 16'hffff};
   int          n_fail = 0, num_checks = 0, cyc = 0, ntog, sel, psel, dc, dc0;
   int          tog [2];
   lcw_driver #(.NUM_SEG(16), .DIV(DV)) i_lcw_driver (.clock(clock),
      .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sleep_in(sleep_in),
      .com_level(com_level), .seg_level(seg_level),
      .charge_pump_on(charge_pump_on), .bias_c_type(bias_c_type));
   lcw_panel #(.NUM_SEG(16)) i_lcw_panel (.clock(clock),
      .com_level(com_level), .seg_level(seg_level), .dc_sum(dc));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t exp %h got %h", $time, exp, got);
      end
   endtask : chk
   // One access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // All drive at ground and pump off
   task automatic chk_off();
      chk(32'h0, {23'h0, charge_pump_on, com_level});
      chk(32'h0, seg_level);
   endtask : chk_off
   task automatic conclude();
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   // ----------------------------------------
   // Clock, timeout and waveform monitor
   // ----------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         conclude();
      end
   end
   // Rebuild expected levels from the selected common and memory
   always @(posedge clock)
   begin
      if (mon_on)
      begin
         sel = 0;
         for (int c = 0; c < 4; c++)
            if (com_level[c*2+:2] inside {LVL_VA, LVL_GND})
               sel = c;
         pol = (com_level[sel*2+:2] == LVL_GND);
         ec = '0;
         for (int c = 0; c < 4; c++)
            ec[c*2+:2] = (c == sel) ? (pol ? LVL_GND : LVL_VA)
                                    : (pol ? LVL_VB : LVL_VC);
         for (int s = 0; s < 16; s++)
            es[s*2+:2] = mem[sel][s] ? (pol ? LVL_VA : LVL_GND)
                                     : (pol ? LVL_VC : LVL_VB);
         chk(ec, 32'(com_level));
         chk(es, seg_level);
         if (!first && sel != psel)
            chk(32'((psel + 1) % 4), 32'(sel));
         if (!first && com_level != prev_com)
            ntog++;
         first = 1'b0;
         psel = sel;
         prev_com = com_level;
      end
      else
         first = 1'b1;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      srst = 1'b1;
      {avs_read, avs_write, sleep_in, mon_on} = '0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(32'h0, q);
      chk_off();
      bus(1'b0, 4'hf, 32'h0);
      chk(32'h0, q);
      for (int c = 0; c < 4; c++)
         bus(1'b1, ADDR_MEM + 4'(c), {16'h0, mem[c]});
      for (int t = 0; t < 2; t++)
      begin
         bus(1'b1, ADDR_CTRL, {29'h0, 1'(t), 1'(t), 1'b1});
         repeat (3) @(posedge clock);
         chk(t ? 32'h3 : 32'h0, {30'h0, charge_pump_on, bias_c_type});
         ntog = 0;
         dc0 = dc;
         mon_on <= 1'b1;
         // Window spans whole polarity periods, so net drive is zero
         repeat (64) @(posedge clock);
         chk(32'h0, 32'(dc - dc0));
         mon_on <= 1'b0;
         @(posedge clock);
         tog[t] = ntog;
      end
      chk(32'h1, 32'(tog[1] < tog[0]));
      sleep_in <= 1'b1;
      repeat (3) @(posedge clock);
      chk_off();
      sleep_in <= 1'b0;
      bus(1'b1, ADDR_CTRL, 32'h0);
      repeat (3) @(posedge clock);
      chk_off();
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(32'h2, q);
      bus(1'b0, ADDR_MEM + 4'h1, 32'h0);
      chk({16'h0, mem[1]}, q);
      bus(1'b1, ADDR_CTRL, 32'h5);
      repeat (3) @(posedge clock);
      chk(32'h1, {31'h0, charge_pump_on});
      bus(1'b1, ADDR_CTRL, 32'hd);
      repeat (3) @(posedge clock);
      chk_off();
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(32'hd, q);
      conclude();
   end
endmodule : tb_lcw_driver
